// >>> hdl/sgien_defs.svh
// Field positions, register selects and reset values of the SGI request and sysreg enable block.
`ifndef SGIEN_DEFS_SVH
`define SGIEN_DEFS_SVH

`define SGIEN_AFFINITY_LEVEL3_MSB 55
`define SGIEN_AFFINITY_LEVEL3_LSB 48
`define SGIEN_IRM_BIT 40
`define SGIEN_AFFINITY_LEVEL2_MSB 39
`define SGIEN_AFFINITY_LEVEL2_LSB 32
`define SGIEN_INTERRUPT_IDENTIFIER_MSB 27
`define SGIEN_INTERRUPT_IDENTIFIER_LSB 24
`define SGIEN_AFFINITY_LEVEL1_MSB 23
`define SGIEN_AFFINITY_LEVEL1_LSB 16
`define SGIEN_TGT_MSB 15
`define SGIEN_TGT_LSB 0

`define SGIEN_DIB_BIT 2
`define SGIEN_DFB_BIT 1
`define SGIEN_SRE_BIT 0

`define SGIEN_SEL_GENERATE 1'b0
`define SGIEN_SEL_ENABLE 1'b1

`define SGIEN_SRE_RST 1'b0
`define SGIEN_DIB_RST 1'b0
`define SGIEN_DFB_RST 1'b0

`define SGIEN_EL0 2'h0
`define SGIEN_EL1 2'h1
`define SGIEN_EL2 2'h2
`define SGIEN_EL3 2'h3

`endif

// >>> hdl/sgien_pkg.sv
// Types shared by the SGI request and sysreg enable block.
package sgien_pkg;

  typedef enum logic [1:0] {
    SGIEN_RESP_OK,
    SGIEN_RESP_UNDEF,
    SGIEN_RESP_TRAP_EL2,
    SGIEN_RESP_TRAP_EL3
  } sgien_resp_e;

  typedef struct packed {
    logic valid;
    logic write;
    logic sel;
    logic [1:0] el;
    logic nonsecure;
    logic [63:0] wdata;
  } sgien_access_s;

  typedef struct packed {
    logic el2_present;
    logic el3_present;
    logic disable_security_flag;
    logic irq_bypass_supported;
    logic fiq_bypass_supported;
    logic sysreg_only;
    logic hyp_fiq_override;
    logic hyp_irq_override;
    logic hyp_register_trap;
    logic hyp_trap_common;
    logic monitor_fiq_routing;
    logic monitor_irq_routing;
    logic [2:0] monitor_level_enable_control;
    logic [2:0] hypervisor_level_enable_control;
  } sgien_ctrl_s;

  typedef struct packed {
    logic group1;
    logic nonsecure;
    logic routing_mode_bit;
    logic [3:0] interrupt_identifier;
    logic [7:0] affinity_level3;
    logic [7:0] affinity_level2;
    logic [7:0] affinity_level1;
    logic [15:0] target_bitmap;
  } sgien_sgi_req_s;

  typedef struct packed {
    logic sysreg_enable_bit;
    logic irq_bypass_disable;
    logic dfb;
    logic resp_valid;
    sgien_resp_e resp_code;
    logic [31:0] rdata;
    logic sgi_valid;
    sgien_sgi_req_s sgi;
    logic eff_sre;
    logic eff_dib;
    logic eff_dfb;
  } sgien_state_s;

endpackage

// >>> hdl/sgien_top.sv
// Processor-side group 1 SGI generate register and system register enable control.
`timescale 1ns/1ps
`include "sgien_defs.svh"

module sgien_top
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // System register access port
  input wire sgien_pkg::sgien_access_s access_i,
  input wire sgien_pkg::sgien_ctrl_s ctrl_i,
  // Access answer
  output logic resp_valid_o,
  output sgien_pkg::sgien_resp_e resp_code_o,
  output logic [31:0] rdata_o,
  // Request towards the distributor
  output logic sgi_valid_o,
  output sgien_pkg::sgien_sgi_req_s sgi_o,
  // Effective interface controls
  output logic sysreg_enable_o,
  output logic irq_bypass_disable_o,
  output logic fiq_bypass_disable_o
);
  import sgien_pkg::*;

  sgien_state_s st;
  sgien_state_s next_st;

  // Bypass-disable read value for the current configuration.
  function automatic logic bypass_view(input logic supported, input logic local_bit, input logic mon_bit,
                                       input logic hyp_bit, input sgien_ctrl_s c);
    if (!supported)
    begin
      return 1'b1;
    end
    if (c.el3_present && !c.disable_security_flag)
    begin
      return mon_bit;
    end
    if (c.el3_present && !c.el2_present)
    begin
      return local_bit;
    end
    return hyp_bit;
  endfunction

  // The local copy stands for the monitor bit only in the read-write alias case.
  function automatic logic bypass_rw(input logic supported, input sgien_ctrl_s c);
    return supported && c.el3_present && c.disable_security_flag && !c.el2_present;
  endfunction

  logic cur_sre;
  logic cur_dib;
  logic cur_dfb;
  logic gen_access;
  logic gen_ok;
  logic governing_sre;
  logic eff_ns;
  logic el1_hyp_trap;
  logic mon_route;

  always_comb
  begin
    next_st = st;
    next_st.resp_valid = 1'b0;
    next_st.sgi_valid = 1'b0;
    gen_ok = 1'b0;
    cur_sre = ctrl_i.sysreg_only ? 1'b1 : st.sysreg_enable_bit;
    cur_dib = bypass_view(ctrl_i.irq_bypass_supported, st.irq_bypass_disable, ctrl_i.monitor_level_enable_control[`SGIEN_DIB_BIT],
                          ctrl_i.hypervisor_level_enable_control[`SGIEN_DIB_BIT], ctrl_i);
    cur_dfb = bypass_view(ctrl_i.fiq_bypass_supported, st.dfb, ctrl_i.monitor_level_enable_control[`SGIEN_DFB_BIT],
                          ctrl_i.hypervisor_level_enable_control[`SGIEN_DFB_BIT], ctrl_i);
    // Monitor-level accesses count as secure whatever the caller claims.
    eff_ns = access_i.nonsecure && (access_i.el != `SGIEN_EL3);
    mon_route = ctrl_i.monitor_fiq_routing && ctrl_i.monitor_irq_routing;
    el1_hyp_trap = ctrl_i.hyp_fiq_override || ctrl_i.hyp_irq_override || ctrl_i.hyp_register_trap
                   || ctrl_i.hyp_trap_common;
    case (access_i.el)
      `SGIEN_EL1: governing_sre = cur_sre;
      `SGIEN_EL2: governing_sre = ctrl_i.hypervisor_level_enable_control[`SGIEN_SRE_BIT];
      `SGIEN_EL3: governing_sre = ctrl_i.monitor_level_enable_control[`SGIEN_SRE_BIT];
      default: governing_sre = 1'b0;
    endcase
    gen_access = access_i.valid && (access_i.sel == `SGIEN_SEL_GENERATE);

    if (access_i.valid)
    begin
      next_st.resp_valid = 1'b1;
      next_st.resp_code = SGIEN_RESP_OK;
      next_st.rdata = 32'h0;
      if (access_i.el == `SGIEN_EL0)
      begin
        next_st.resp_code = SGIEN_RESP_UNDEF;
      end
      else if (gen_access)
      begin
        if (!access_i.write)
        begin
          next_st.resp_code = SGIEN_RESP_UNDEF;
        end
        else if (!governing_sre)
        begin
          next_st.resp_code = SGIEN_RESP_UNDEF;
        end
        else if ((access_i.el == `SGIEN_EL1) && eff_ns && el1_hyp_trap)
        begin
          next_st.resp_code = SGIEN_RESP_TRAP_EL2;
        end
        else if (mon_route && (access_i.el != `SGIEN_EL3))
        begin
          // Secure and non-overridden EL1 writes also go to the monitor under full routing.
          next_st.resp_code = SGIEN_RESP_TRAP_EL3;
        end
        else
        begin
          gen_ok = 1'b1;
        end
      end
      else if (access_i.write)
      begin
        if (!ctrl_i.sysreg_only)
        begin
          next_st.sysreg_enable_bit = access_i.wdata[`SGIEN_SRE_BIT];
        end
        if (bypass_rw(ctrl_i.irq_bypass_supported, ctrl_i))
        begin
          next_st.irq_bypass_disable = access_i.wdata[`SGIEN_DIB_BIT];
        end
        if (bypass_rw(ctrl_i.fiq_bypass_supported, ctrl_i))
        begin
          next_st.dfb = access_i.wdata[`SGIEN_DFB_BIT];
        end
      end
      else
      begin
        next_st.rdata = {29'h0, cur_dib, cur_dfb, cur_sre};
      end
    end

    // The distributor has no stall path, so every accepted write is handed over at once.
    if (gen_ok)
    begin
      next_st.sgi_valid = 1'b1;
      next_st.sgi.group1 = 1'b1;
      next_st.sgi.nonsecure = eff_ns;
      next_st.sgi.routing_mode_bit = access_i.wdata[`SGIEN_IRM_BIT];
      next_st.sgi.interrupt_identifier = access_i.wdata[`SGIEN_INTERRUPT_IDENTIFIER_MSB:`SGIEN_INTERRUPT_IDENTIFIER_LSB];
      if (access_i.wdata[`SGIEN_IRM_BIT])
      begin
        next_st.sgi.affinity_level3 = 8'h0;
        next_st.sgi.affinity_level2 = 8'h0;
        next_st.sgi.affinity_level1 = 8'h0;
        next_st.sgi.target_bitmap = 16'h0;
      end
      else
      begin
        next_st.sgi.affinity_level3 = access_i.wdata[`SGIEN_AFFINITY_LEVEL3_MSB:`SGIEN_AFFINITY_LEVEL3_LSB];
        next_st.sgi.affinity_level2 = access_i.wdata[`SGIEN_AFFINITY_LEVEL2_MSB:`SGIEN_AFFINITY_LEVEL2_LSB];
        next_st.sgi.affinity_level1 = access_i.wdata[`SGIEN_AFFINITY_LEVEL1_MSB:`SGIEN_AFFINITY_LEVEL1_LSB];
        // Bits naming absent elements pass unchanged; the distributor drops them.
        next_st.sgi.target_bitmap = access_i.wdata[`SGIEN_TGT_MSB:`SGIEN_TGT_LSB];
      end
    end

    next_st.eff_sre = cur_sre;
    next_st.eff_dib = cur_dib;
    next_st.eff_dfb = cur_dfb;
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      st <= '0;
      st.sysreg_enable_bit <= `SGIEN_SRE_RST;
      st.irq_bypass_disable <= `SGIEN_DIB_RST;
      st.dfb <= `SGIEN_DFB_RST;
      st.resp_code <= SGIEN_RESP_OK;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign resp_valid_o = st.resp_valid;
  assign resp_code_o = st.resp_code;
  assign rdata_o = st.rdata;
  assign sgi_valid_o = st.sgi_valid;
  assign sgi_o = st.sgi;
  assign sysreg_enable_o = st.eff_sre;
  assign irq_bypass_disable_o = st.eff_dib;
  assign fiq_bypass_disable_o = st.eff_dfb;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence s_gen_write;
    access_i.valid && access_i.write && (access_i.sel == `SGIEN_SEL_GENERATE);
  endsequence

  // A request in the following cycle is allowed only when the cycle showing the first request accepted another write.
  sequence s_one_request;
    sgi_valid_o && resp_valid_o && (resp_code_o == SGIEN_RESP_OK) ##1 (sgi_valid_o == $past(gen_ok));
  endsequence

  property p_one_request;
    s_gen_write ##0 gen_ok |=> s_one_request;
  endproperty
  a_one_request: assert property (p_one_request) else $error("accepted write gave no single request");

  property p_sgi_fields;
    s_gen_write ##0 gen_ok |=> (sgi_o.interrupt_identifier == $past(access_i.wdata[27:24]))
      && (sgi_o.routing_mode_bit == $past(access_i.wdata[40])) && sgi_o.group1;
  endproperty
  a_sgi_fields: assert property (p_sgi_fields) else $error("request fields differ from written value");

  property p_routed_targets;
    s_gen_write ##0 (gen_ok && !access_i.wdata[40]) |=> (sgi_o.target_bitmap == $past(access_i.wdata[15:0]))
      && (sgi_o.affinity_level3 == $past(access_i.wdata[55:48]));
  endproperty
  a_routed_targets: assert property (p_routed_targets) else $error("target or affinity not carried");

  property p_broadcast_clean;
    sgi_valid_o && sgi_o.routing_mode_bit |-> (sgi_o.target_bitmap == 16'h0) && (sgi_o.affinity_level1 == 8'h0)
      && (sgi_o.affinity_level2 == 8'h0) && (sgi_o.affinity_level3 == 8'h0);
  endproperty
  a_broadcast_clean: assert property (p_broadcast_clean) else $error("broadcast request kept fields");

  property p_el0_undef;
    access_i.valid && (access_i.el == `SGIEN_EL0) |=> resp_valid_o && (resp_code_o == SGIEN_RESP_UNDEF) && !sgi_valid_o;
  endproperty
  a_el0_undef: assert property (p_el0_undef) else $error("exception level 0 access not refused");

  property p_sre_undef;
    s_gen_write ##0 (access_i.el == `SGIEN_EL1) && !ctrl_i.sysreg_only && !st.sysreg_enable_bit
      |=> (resp_code_o == SGIEN_RESP_UNDEF) && !sgi_valid_o;
  endproperty
  a_sre_undef: assert property (p_sre_undef) else $error("write with enable clear not undefined");

  property p_trap_el2;
    s_gen_write ##0 (access_i.el == `SGIEN_EL1) && access_i.nonsecure && st.sysreg_enable_bit && ctrl_i.hyp_trap_common
      |=> resp_code_o == SGIEN_RESP_TRAP_EL2;
  endproperty
  a_trap_el2: assert property (p_trap_el2) else $error("non-secure EL1 write not trapped to EL2");

  property p_trap_el3;
    s_gen_write ##0 (access_i.el == `SGIEN_EL2) && ctrl_i.hypervisor_level_enable_control[0]
      && ctrl_i.monitor_fiq_routing && ctrl_i.monitor_irq_routing |=> resp_code_o == SGIEN_RESP_TRAP_EL3;
  endproperty
  a_trap_el3: assert property (p_trap_el3) else $error("EL2 write not trapped to EL3");

  property p_read_upper_zero;
    resp_valid_o |-> rdata_o[31:3] == 29'h0;
  endproperty
  a_read_upper_zero: assert property (p_read_upper_zero) else $error("reserved enable bits read nonzero");

  property p_bypass_rao;
    access_i.valid && !access_i.write && (access_i.sel == `SGIEN_SEL_ENABLE) && (access_i.el != `SGIEN_EL0)
      && !ctrl_i.irq_bypass_supported |=> rdata_o[2];
  endproperty
  a_bypass_rao: assert property (p_bypass_rao) else $error("unsupported IRQ bypass bit not one");

  property p_sre_only;
    access_i.valid && !access_i.write && (access_i.sel == `SGIEN_SEL_ENABLE) && (access_i.el != `SGIEN_EL0)
      && ctrl_i.sysreg_only |=> rdata_o[0];
  endproperty
  a_sre_only: assert property (p_sre_only) else $error("sysreg-only enable bit not one");

  sequence s_enable_read;
    access_i.valid && !access_i.write && (access_i.sel == `SGIEN_SEL_ENABLE) && (access_i.el != `SGIEN_EL0);
  endsequence

  property p_refused_silent;
    resp_valid_o && (resp_code_o != SGIEN_RESP_OK) |-> !sgi_valid_o;
  endproperty
  a_refused_silent: assert property (p_refused_silent) else $error("refused access raised a request");

  property p_answer_each;
    access_i.valid |=> resp_valid_o;
  endproperty
  a_answer_each: assert property (p_answer_each) else $error("access left without an answer");

  property p_request_from_write;
    sgi_valid_o |-> $past(access_i.valid && access_i.write && (access_i.sel == `SGIEN_SEL_GENERATE)
      && (access_i.el != `SGIEN_EL0));
  endproperty
  a_request_from_write: assert property (p_request_from_write) else $error("request with no write");

  property p_monitor_secure;
    s_gen_write ##0 (gen_ok && (access_i.el == `SGIEN_EL3)) |=> !sgi_o.nonsecure;
  endproperty
  a_monitor_secure: assert property (p_monitor_secure) else $error("monitor request marked non-secure");

  property p_monitor_alias;
    s_enable_read ##0 (ctrl_i.el3_present && !ctrl_i.disable_security_flag && ctrl_i.irq_bypass_supported
      && ctrl_i.fiq_bypass_supported) |=> rdata_o[2:1] == $past(ctrl_i.monitor_level_enable_control[2:1]);
  endproperty
  a_monitor_alias: assert property (p_monitor_alias) else $error("bypass bits not monitor copy");

  property p_hyp_alias;
    s_enable_read ##0 (ctrl_i.el2_present && (!ctrl_i.el3_present || ctrl_i.disable_security_flag)
      && ctrl_i.irq_bypass_supported && ctrl_i.fiq_bypass_supported)
      |=> rdata_o[2:1] == $past(ctrl_i.hypervisor_level_enable_control[2:1]);
  endproperty
  a_hyp_alias: assert property (p_hyp_alias) else $error("bypass bits not hypervisor copy");

  property p_sre_write;
    access_i.valid && access_i.write && (access_i.sel == `SGIEN_SEL_ENABLE) && (access_i.el != `SGIEN_EL0)
      && !ctrl_i.sysreg_only |=> st.sysreg_enable_bit == $past(access_i.wdata[`SGIEN_SRE_BIT]);
  endproperty
  a_sre_write: assert property (p_sre_write) else $error("enable bit write not stored");

  property p_affinity_mid;
    s_gen_write ##0 (gen_ok && !access_i.wdata[40]) |=> (sgi_o.affinity_level2 == $past(access_i.wdata[39:32]))
      && (sgi_o.affinity_level1 == $past(access_i.wdata[23:16]));
  endproperty
  a_affinity_mid: assert property (p_affinity_mid) else $error("affinity levels 2 or 1 not carried");

  property p_any_override;
    s_gen_write ##0 ((access_i.el == `SGIEN_EL1) && access_i.nonsecure && (st.sysreg_enable_bit || ctrl_i.sysreg_only)
      && (ctrl_i.hyp_fiq_override || ctrl_i.hyp_irq_override || ctrl_i.hyp_register_trap))
      |=> resp_code_o == SGIEN_RESP_TRAP_EL2;
  endproperty
  a_any_override: assert property (p_any_override) else $error("override did not trap to EL2");

  // The first cycle after reset still shows the reset value, so it is skipped.
  property p_eff_sre;
    $past(rst_b_i) |-> sysreg_enable_o == $past(ctrl_i.sysreg_only || st.sysreg_enable_bit);
  endproperty
  a_eff_sre: assert property (p_eff_sre) else $error("effective enable level wrong");

endmodule

// >>> tb/sgien_dist_model.sv
// Behavioural distributor that takes the block's SGI requests.
`timescale 1ns/1ps

module sgien_dist_model
#(
  parameter int NUM_PE = 4
)
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // Request from the block
  input wire logic sgi_valid_i,
  input wire sgien_pkg::sgien_sgi_req_s sgi_i,
  // Observation
  output logic [15:0] req_count_o,
  output logic [15:0] delivered_o
);
  import sgien_pkg::*;

  localparam logic [15:0] pe_mask = 16'((1 << NUM_PE) - 1);

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      req_count_o <= 16'h0;
      delivered_o <= 16'h0;
    end
    else if (sgi_valid_i)
    begin
      // There is no ready line, so every pulse is taken, even one that is later discarded.
      req_count_o <= req_count_o + 16'h1;
      // Bits that name an absent element are dropped without raising any error.
      delivered_o <= sgi_i.routing_mode_bit ? pe_mask : (sgi_i.target_bitmap & pe_mask);
    end
  end
endmodule

// >>> tb/testbench.sv
// Self-checking testbench of the SGI request and sysreg enable block.
`timescale 1ns/1ps
`include "sgien_defs.svh"

module testbench;
  import sgien_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  sgien_access_s access_i = '0;
  sgien_ctrl_s ctrl_i = '0;
  logic resp_valid_o;
  sgien_resp_e resp_code_o;
  logic [31:0] rdata_o;
  logic sgi_valid_o;
  sgien_sgi_req_s sgi_o;
  logic sysreg_enable_o;
  logic irq_bypass_disable_o;
  logic fiq_bypass_disable_o;
  logic [15:0] req_count;
  logic [15:0] delivered;
  sgien_resp_e got_code;
  logic [31:0] got_rdata;
  logic got_sgi;
  int err_count = 0;
  int n_compared = 0;
  // Reserved bits are set on purpose; the target list only names elements below 16.
  logic [63:0] wd_a = 64'hff5a_fe34_f7c3_8421;
  logic [63:0] wd_b = 64'h005a_0134_03c3_8421;

  always #25 clk_sys_i = ~clk_sys_i;

  sgien_top i_sgien_top (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .access_i(access_i), .ctrl_i(ctrl_i),
    .resp_valid_o(resp_valid_o), .resp_code_o(resp_code_o), .rdata_o(rdata_o),
    .sgi_valid_o(sgi_valid_o), .sgi_o(sgi_o), .sysreg_enable_o(sysreg_enable_o),
    .irq_bypass_disable_o(irq_bypass_disable_o), .fiq_bypass_disable_o(fiq_bypass_disable_o));

  sgien_dist_model i_sgien_dist_model (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .sgi_valid_i(sgi_valid_o), .sgi_i(sgi_o),
    .req_count_o(req_count), .delivered_o(delivered));

  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk64(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_resp(input sgien_resp_e exp, input logic exp_sgi);
    n_compared++;
    if ({got_code, got_sgi} !== {exp, exp_sgi})
    begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, {got_code, got_sgi}, {exp, exp_sgi});
    end
  endtask

  // One access; the answer is read at the edge after the taking edge, before that edge's updates land,
  // so the task ends on a rising edge and the caller may drive inputs there.
  task automatic acc(input logic [1:0] a_el, input logic a_ns, input logic a_wr, input logic a_sel,
                     input logic [63:0] a_wd);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    access_i <= '{valid: 1'b1, write: a_wr, sel: a_sel, el: a_el, nonsecure: a_ns, wdata: a_wd};
    @(posedge clk_sys_i);
    access_i.valid <= 1'b0;
    @(posedge clk_sys_i);
    while (resp_valid_o !== 1'b1 && n < 4)
    begin
      @(posedge clk_sys_i);
      n++;
    end
    got_code = resp_code_o;
    got_rdata = rdata_o;
    got_sgi = sgi_valid_o;
    chk64(64'(n), 64'h0);
  endtask

  task automatic gw(input logic [1:0] a_el, input logic a_ns, input logic [63:0] a_wd,
                    input sgien_resp_e exp, input logic exp_sgi);
    acc(a_el, a_ns, 1'b1, `SGIEN_SEL_GENERATE, a_wd);
    chk_resp(exp, exp_sgi);
  endtask

  task automatic rd(input logic [31:0] exp);
    acc(`SGIEN_EL1, 1'b1, 1'b0, `SGIEN_SEL_ENABLE, 64'h0);
    chk_resp(SGIEN_RESP_OK, 1'b0);
    chk64(64'(got_rdata), 64'(exp));
  endtask

  initial
  begin
    repeat (2000) @(posedge clk_sys_i);
    err_count++;
    summarize();
  end

  initial
  begin
    ctrl_i.el3_present = 1'b1;
    ctrl_i.disable_security_flag = 1'b1;
    ctrl_i.irq_bypass_supported = 1'b1;
    ctrl_i.fiq_bypass_supported = 1'b1;
    ctrl_i.monitor_level_enable_control = 3'b001;
    ctrl_i.hypervisor_level_enable_control = 3'b001;
    repeat (20) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    @(posedge clk_sys_i);
    chk64({62'h0, resp_valid_o, sgi_valid_o}, 64'h0);
    gw(`SGIEN_EL1, 1'b1, wd_a, SGIEN_RESP_UNDEF, 1'b0);
    rd(32'h0);
    // Enable writes come from the non-secure side only.
    acc(`SGIEN_EL1, 1'b1, 1'b1, `SGIEN_SEL_ENABLE, 64'hffff_ffff_ffff_fff7);
    chk_resp(SGIEN_RESP_OK, 1'b0);
    rd(32'h7);
    chk64({61'h0, sysreg_enable_o, irq_bypass_disable_o, fiq_bypass_disable_o}, 64'h7);
    gw(`SGIEN_EL1, 1'b1, wd_a, SGIEN_RESP_OK, 1'b1);
    chk64(64'(sgi_o), 64'(sgien_sgi_req_s'{1'b1, 1'b1, 1'b0, 4'h7, 8'h5a, 8'h34, 8'hc3, 16'h8421}));
    gw(`SGIEN_EL1, 1'b1, wd_b, SGIEN_RESP_OK, 1'b1);
    chk64(64'(sgi_o), 64'(sgien_sgi_req_s'{1'b1, 1'b1, 1'b1, 4'h3, 8'h0, 8'h0, 8'h0, 16'h0}));
    gw(`SGIEN_EL0, 1'b1, wd_a, SGIEN_RESP_UNDEF, 1'b0);
    acc(`SGIEN_EL1, 1'b1, 1'b0, `SGIEN_SEL_GENERATE, 64'h0);
    chk_resp(SGIEN_RESP_UNDEF, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      {ctrl_i.hyp_fiq_override, ctrl_i.hyp_irq_override, ctrl_i.hyp_register_trap, ctrl_i.hyp_trap_common} <= 4'h1 << i;
      gw(`SGIEN_EL1, 1'b1, wd_a, SGIEN_RESP_TRAP_EL2, 1'b0);
    end
    gw(`SGIEN_EL1, 1'b0, wd_a, SGIEN_RESP_OK, 1'b1);
    ctrl_i.hyp_fiq_override <= 1'b0;
    ctrl_i.monitor_fiq_routing <= 1'b1;
    ctrl_i.monitor_irq_routing <= 1'b1;
    gw(`SGIEN_EL2, 1'b1, wd_a, SGIEN_RESP_TRAP_EL3, 1'b0);
    gw(`SGIEN_EL3, 1'b1, wd_a, SGIEN_RESP_OK, 1'b1);
    chk64(64'(sgi_o.nonsecure), 64'h0);
    ctrl_i.hypervisor_level_enable_control <= 3'b100;
    gw(`SGIEN_EL2, 1'b1, wd_a, SGIEN_RESP_UNDEF, 1'b0);
    ctrl_i.monitor_level_enable_control <= 3'b000;
    gw(`SGIEN_EL3, 1'b1, wd_a, SGIEN_RESP_UNDEF, 1'b0);
    chk64(64'(req_count), 64'h4);
    chk64(64'(delivered), 64'h0001);
    ctrl_i.disable_security_flag <= 1'b0;
    rd(32'h1);
    ctrl_i.disable_security_flag <= 1'b1;
    ctrl_i.el2_present <= 1'b1;
    rd(32'h5);
    ctrl_i.irq_bypass_supported <= 1'b0;
    ctrl_i.fiq_bypass_supported <= 1'b0;
    ctrl_i.sysreg_only <= 1'b1;
    acc(`SGIEN_EL1, 1'b1, 1'b1, `SGIEN_SEL_ENABLE, 64'h0);
    chk_resp(SGIEN_RESP_OK, 1'b0);
    rd(32'h7);
    chk64({61'h0, sysreg_enable_o, irq_bypass_disable_o, fiq_bypass_disable_o}, 64'h7);
    summarize();
  end
endmodule
